// >>> verilog/alu_pkg.sv
// Shared types, operation codes and constants of the 8-bit arithmetic and logic unit
package alu_pkg;

  // Operation selector presented with each request
  typedef enum logic [4:0] {
    OP_REG_SUM,
    OP_REG_SUM_CARRY,
    OP_WORD_SUM_IMMEDIATE,
    OP_REG_DIFFERENCE,
    OP_DIFFERENCE_CONSTANT,
    OP_DIFFERENCE_WITH_BORROW,
    OP_DIFFERENCE_BORROW_CONSTANT,
    OP_WORD_DIFFERENCE_IMMEDIATE,
    OP_CONJUNCTION,
    OP_CONJUNCTION_CONSTANT,
    OP_DISJUNCTION,
    OP_DISJUNCTION_CONSTANT,
    OP_EXCLUSIVE_DISJUNCTION,
    OP_BIT_INVERSION,
    OP_ARITHMETIC_INVERSE,
    OP_MASK_SET_BITS,
    OP_MASK_CLEAR_BITS,
    OP_PLUS_ONE,
    OP_MINUS_ONE,
    OP_ZERO_SIGN_CHECK,
    OP_ZERO_REGISTER,
    OP_ALL_ONES_REGISTER,
    OP_UNSIGNED_PRODUCT,
    OP_SIGNED_PRODUCT,
    OP_MIXED_SIGN_PRODUCT,
    OP_FRACTIONAL_UNSIGNED_PRODUCT,
    OP_FRACTIONAL_SIGNED_PRODUCT,
    OP_FRACTIONAL_MIXED_PRODUCT
  } alu_op_t;

  // Where the core must write the result
  typedef enum logic [1:0] {
    TARGET_NONE,
    TARGET_BYTE,
    TARGET_PAIR,
    TARGET_PRODUCT
  } target_t;

  // Status register image, bit 7 down to bit 0
  typedef struct packed {
    logic i;
    logic t;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } status_t;

  // One request from the decoder: operands read from the register file
  typedef struct packed {
    alu_op_t op;
    logic [7:0] dst;
    logic [7:0] src;
    logic [7:0] imm;
    logic [15:0] pair;
  } alu_req_t;

  // Byte result with its flags
  typedef struct packed {
    status_t f;
    logic [7:0] r;
  } byte_out_t;

  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] SIGN_MIN = 8'h80;
  localparam logic [7:0] SIGN_MAX = 8'h7F;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam int FAST_CYCLES = 1;
  localparam int SLOW_CYCLES = 2;

  // Two-cycle operations: word arithmetic and all products
  function automatic logic is_slow(input alu_op_t op);
    return op inside {OP_WORD_SUM_IMMEDIATE, OP_WORD_DIFFERENCE_IMMEDIATE,
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT,
      OP_FRACTIONAL_MIXED_PRODUCT};
  endfunction

endpackage

// >>> verilog/product_unit.sv
// Combinational 8x8 multiplier with signed, unsigned, mixed and fractional forms
`timescale 1ns/100ps
module product_unit
(
  // Operands
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  // Form of the product
  input wire logic signed_a_i,
  input wire logic signed_b_i,
  input wire logic fractional_i,
  // Result
  output logic [15:0] product_o,
  output logic carry_o
);
  logic signed [17:0] full;
  logic [15:0] raw;

  // Extending to nine bits lets one signed multiplier serve all three sign forms
  always_comb
  begin
    full = $signed({signed_a_i & a_i[7], a_i}) * $signed({signed_b_i & b_i[7], b_i});
    raw = full[15:0];
    carry_o = raw[15]; // Carry is taken before the fractional shift
    product_o = fractional_i ? {raw[14:0], 1'b0} : raw;
  end
endmodule

// >>> verilog/eight_bit_arith_logic_unit.sv
// Arithmetic and logic datapath of an 8-bit core, one- and two-cycle operations
`timescale 1ns/100ps
// Behaviour
// - Sum of two registers, optionally plus carry; Z C N V H; one cycle.
// - Word pair plus immediate back to pair; Z C N V S; two cycles.
// - Destination minus constant or register; Z C N V H; one cycle.
// - Destination minus source minus carry, register form; Z C N V H; one cycle.
// - Destination minus constant minus carry; Z C N V H; one cycle.
// - Word pair minus immediate back to pair; Z C N V S; two cycles.
// - Conjunction with register or constant; only Z N V change; one cycle.
// - Disjunction with register or constant; only Z N V change; one cycle.
// - Set bits is disjunction with immediate mask; Z N V; one cycle.
// - Clear bits is conjunction with FF minus immediate; Z N V; one cycle.
// - Test is register conjunction with itself; Z N V; one cycle.
// - Unsigned, signed, mixed products into product pair; Z C; two cycles.
// - Fractional products shifted left one bit into product pair; Z C; two cycles.
module eight_bit_arith_logic_unit
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Request from the decoder
  input wire logic start_i,
  input wire alu_pkg::alu_req_t req_i,
  input wire alu_pkg::status_t flags_i,
  output logic ready_o,
  // Answer to the register file
  output logic done_o,
  output alu_pkg::target_t target_o,
  output logic [15:0] result_o,
  output alu_pkg::status_t flags_o
);
  import alu_pkg::*;

  typedef enum logic {ST_IDLE, ST_SECOND} state_t;

  state_t state_reg;
  alu_req_t req_reg;
  status_t flags_hold_reg;
  logic accept;
  logic finish;
  alu_req_t cur;
  status_t cur_f;
  logic [15:0] res_next;
  status_t flags_next;
  target_t target_next;
  logic [15:0] product;
  logic prod_carry;
  logic prod_signed_a;
  logic prod_signed_b;
  logic prod_frac;

  // Byte add with carry-in
  function automatic byte_out_t sum_byte(input logic [7:0] a, input logic [7:0] b,
    input logic cin, input status_t f);
    logic [8:0] s;
    logic [4:0] lo;
    byte_out_t o;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    o.r = s[7:0];
    o.f = f;
    o.f.c = s[8];
    o.f.h = lo[4];
    o.f.n = s[7];
    o.f.z = (s[7:0] == ZERO_BYTE);
    o.f.v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
    return o;
  endfunction

  // Byte subtract with borrow-in; chained zero keeps multi-byte compares correct
  function automatic byte_out_t diff_byte(input logic [7:0] a, input logic [7:0] b,
    input logic cin, input logic chain, input status_t f);
    logic [8:0] s;
    logic [4:0] lo;
    byte_out_t o;
    s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    o.r = s[7:0];
    o.f = f;
    o.f.c = s[8];
    o.f.h = lo[4];
    o.f.n = s[7];
    o.f.z = (s[7:0] == ZERO_BYTE) & (~chain | f.z);
    o.f.v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
    return o;
  endfunction

  // Logic result: Z and N follow the value, V cleared, C and H untouched
  function automatic byte_out_t logic_byte(input logic [7:0] r, input status_t f);
    byte_out_t o;
    o.r = r;
    o.f = f;
    o.f.z = (r == ZERO_BYTE);
    o.f.n = r[7];
    o.f.v = 1'b0;
    return o;
  endfunction

  // A new request is taken only while nothing is in flight
  assign ready_o = (state_reg == ST_IDLE);
  assign accept = start_i && ready_o;
  assign finish = (accept && !is_slow(req_i.op)) || (state_reg == ST_SECOND);
  assign cur = (state_reg == ST_SECOND) ? req_reg : req_i;
  assign cur_f = (state_reg == ST_SECOND) ? flags_hold_reg : flags_i;

  // Product form decode
  always_comb
  begin
    prod_signed_a = cur.op inside {OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT};
    prod_signed_b = cur.op inside {OP_SIGNED_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT};
    prod_frac = cur.op inside {OP_FRACTIONAL_UNSIGNED_PRODUCT,
      OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT};
  end

  product_unit u_product
  (
    .a_i(cur.dst),
    .b_i(cur.src),
    .signed_a_i(prod_signed_a),
    .signed_b_i(prod_signed_b),
    .fractional_i(prod_frac),
    .product_o(product),
    .carry_o(prod_carry)
  );

  // Result and flag computation for whichever operation is finishing
  always_comb
  begin
    byte_out_t bo;
    logic [15:0] w;
    bo = '{f: cur_f, r: cur.dst};
    w = ZERO_WORD;
    res_next = ZERO_WORD;
    flags_next = cur_f;
    target_next = TARGET_BYTE;
    unique case (cur.op)
      OP_REG_SUM: bo = sum_byte(cur.dst, cur.src, 1'b0, cur_f);
      OP_REG_SUM_CARRY: bo = sum_byte(cur.dst, cur.src, cur_f.c, cur_f);
      OP_REG_DIFFERENCE: bo = diff_byte(cur.dst, cur.src, 1'b0, 1'b0, cur_f);
      OP_DIFFERENCE_CONSTANT: bo = diff_byte(cur.dst, cur.imm, 1'b0, 1'b0, cur_f);
      OP_DIFFERENCE_WITH_BORROW: bo = diff_byte(cur.dst, cur.src, cur_f.c, 1'b1, cur_f);
      OP_DIFFERENCE_BORROW_CONSTANT:
        bo = diff_byte(cur.dst, cur.imm, cur_f.c, 1'b1, cur_f);
      OP_CONJUNCTION: bo = logic_byte(cur.dst & cur.src, cur_f);
      OP_CONJUNCTION_CONSTANT: bo = logic_byte(cur.dst & cur.imm, cur_f);
      OP_DISJUNCTION: bo = logic_byte(cur.dst | cur.src, cur_f);
      OP_DISJUNCTION_CONSTANT: bo = logic_byte(cur.dst | cur.imm, cur_f);
      OP_MASK_SET_BITS: bo = logic_byte(cur.dst | cur.imm, cur_f);
      OP_MASK_CLEAR_BITS: bo = logic_byte(cur.dst & (ALL_ONES - cur.imm), cur_f);
      OP_ZERO_SIGN_CHECK: bo = logic_byte(cur.dst & cur.dst, cur_f);
      OP_EXCLUSIVE_DISJUNCTION: bo = logic_byte(cur.dst ^ cur.src, cur_f);
      OP_BIT_INVERSION:
      begin
        bo = logic_byte(ALL_ONES - cur.dst, cur_f);
        bo.f.c = 1'b1;
      end
      OP_ARITHMETIC_INVERSE: bo = diff_byte(ZERO_BYTE, cur.dst, 1'b0, 1'b0, cur_f);
      OP_PLUS_ONE:
      begin
        bo = logic_byte(cur.dst + ONE_BYTE, cur_f);
        bo.f.v = (cur.dst == SIGN_MAX);
      end
      OP_MINUS_ONE:
      begin
        bo = logic_byte(cur.dst - ONE_BYTE, cur_f);
        bo.f.v = (cur.dst == SIGN_MIN);
      end
      OP_ZERO_REGISTER: bo = logic_byte(ZERO_BYTE, cur_f);
      OP_ALL_ONES_REGISTER: bo = '{f: cur_f, r: ALL_ONES};
      OP_WORD_SUM_IMMEDIATE, OP_WORD_DIFFERENCE_IMMEDIATE:
      begin
        target_next = TARGET_PAIR;
        if (cur.op == OP_WORD_SUM_IMMEDIATE)
        begin
          w = cur.pair + {8'h00, cur.imm};
          flags_next.v = ~cur.pair[15] & w[15];
          flags_next.c = ~w[15] & cur.pair[15];
        end
        else
        begin
          w = cur.pair - {8'h00, cur.imm};
          flags_next.v = cur.pair[15] & ~w[15];
          flags_next.c = w[15] & ~cur.pair[15];
        end
        flags_next.n = w[15];
        flags_next.z = (w == ZERO_WORD);
        flags_next.s = w[15] ^ flags_next.v;
      end
      default:
      begin
        // Every product form shares this path
        target_next = TARGET_PRODUCT;
        w = product;
        flags_next.c = prod_carry;
        flags_next.z = (product == ZERO_WORD);
      end
    endcase
    if (target_next == TARGET_BYTE)
    begin
      res_next = {ZERO_BYTE, bo.r};
      flags_next = bo.f;
    end
    else
    begin
      res_next = w;
    end
  end

  // Sequencing: slow operations spend one extra cycle in the second state
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_reg <= ST_IDLE;
    else if (accept && is_slow(req_i.op))
      state_reg <= ST_SECOND;
    else
      state_reg <= ST_IDLE;
  end

  // Operands are held so the core may move on to fetch during the second cycle
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_reg <= '0;
      flags_hold_reg <= '0;
    end
    else if (accept)
    begin
      req_reg <= req_i;
      flags_hold_reg <= flags_i;
    end
  end

  // Registered answer; result and flags stand until the next answer
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      done_o <= 1'b0;
      result_o <= ZERO_WORD;
      flags_o <= '0;
      target_o <= TARGET_NONE;
    end
    else
    begin
      done_o <= finish;
      if (finish)
      begin
        result_o <= res_next;
        flags_o <= flags_next;
        target_o <= target_next;
      end
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence take_op(alu_op_t o);
    accept && req_i.op == o;
  endsequence

  sequence two_step_finish;
    !done_o ##1 done_o;
  endsequence

  sum_carry_value_a: assert property (take_op(OP_REG_SUM_CARRY) |=>
    done_o && result_o[7:0] == 8'($past(req_i.dst) + $past(req_i.src) + {7'h00, $past(flags_i.c)}))
    else $error("sum with carry wrong");
  word_sum_timing_a: assert property (take_op(OP_WORD_SUM_IMMEDIATE) |=> two_step_finish
    ##0 target_o == TARGET_PAIR && result_o == 16'($past(req_i.pair, 2) + {8'h00, $past(req_i.imm, 2)}))
    else $error("word sum wrong");
  diff_const_carry_a: assert property (take_op(OP_DIFFERENCE_CONSTANT) |=>
    flags_o.c == ($past(req_i.imm) > $past(req_i.dst)))
    else $error("borrow flag wrong");
  borrow_value_a: assert property (take_op(OP_DIFFERENCE_WITH_BORROW) ##0 flags_i.c |=>
    result_o[7:0] == 8'($past(req_i.dst) - $past(req_i.src) - ONE_BYTE))
    else $error("difference with borrow wrong");
  borrow_const_a: assert property (take_op(OP_DIFFERENCE_BORROW_CONSTANT) |=>
    result_o[7:0] == 8'($past(req_i.dst) - $past(req_i.imm) - {7'h00, $past(flags_i.c)}))
    else $error("constant borrow wrong");
  word_diff_value_a: assert property (take_op(OP_WORD_DIFFERENCE_IMMEDIATE) |-> ##2
    done_o && result_o == 16'($past(req_i.pair, 2) - {8'h00, $past(req_i.imm, 2)}))
    else $error("word difference wrong");
  conj_keeps_carry_a: assert property (take_op(OP_CONJUNCTION) |=>
    flags_o.c == $past(flags_i.c) && flags_o.h == $past(flags_i.h) && !flags_o.v)
    else $error("conjunction touched carry");
  disj_value_a: assert property (take_op(OP_DISJUNCTION_CONSTANT) |=>
    result_o[7:0] == ($past(req_i.dst) | $past(req_i.imm)))
    else $error("disjunction wrong");
  set_bits_a: assert property (take_op(OP_MASK_SET_BITS) |=>
    result_o[7:0] == ($past(req_i.dst) | $past(req_i.imm)) && !flags_o.v)
    else $error("set bits wrong");
  clear_bits_a: assert property (take_op(OP_MASK_CLEAR_BITS) |=>
    result_o[7:0] == ($past(req_i.dst) & ~$past(req_i.imm)))
    else $error("clear bits wrong");
  test_zero_a: assert property (take_op(OP_ZERO_SIGN_CHECK) |=>
    flags_o.z == ($past(req_i.dst) == ZERO_BYTE) && flags_o.n == $past(req_i.dst[7]))
    else $error("test flags wrong");
  product_value_a: assert property (take_op(OP_UNSIGNED_PRODUCT) |=> two_step_finish
    ##0 target_o == TARGET_PRODUCT && result_o == $past(req_i.dst, 2) * $past(req_i.src, 2))
    else $error("product wrong");
  frac_shift_a: assert property (take_op(OP_FRACTIONAL_UNSIGNED_PRODUCT) |-> ##2
    result_o == 16'(({8'h00, $past(req_i.dst, 2)} * {8'h00, $past(req_i.src, 2)}) << 1))
    else $error("fractional product wrong");
  inc_keeps_carry_a: assert property (take_op(OP_PLUS_ONE) |=>
    flags_o.c == $past(flags_i.c) && result_o[7:0] == 8'($past(req_i.dst) + ONE_BYTE))
    else $error("increment wrong");
  ones_no_flags_a: assert property (take_op(OP_ALL_ONES_REGISTER) |=>
    result_o[7:0] == ALL_ONES && flags_o == $past(flags_i))
    else $error("set register changed flags");
endmodule

// >>> verif/regfile_model.sv
// Write-back side of the core: register file image fed by the unit's answers
`timescale 1ns/100ps
module regfile_model
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Answer from the unit
  input wire logic done_i,
  input wire alu_pkg::target_t target_i,
  input wire logic [15:0] result_i,
  input wire alu_pkg::status_t flags_i,
  // Register file image
  output logic [7:0] byte_reg_o,
  output logic [15:0] pair_reg_o,
  output logic [15:0] product_reg_o,
  output alu_pkg::status_t status_reg_o
);
  import alu_pkg::*;

  // Destination byte; only the low half of the answer is meaningful here
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      byte_reg_o <= ZERO_BYTE;
    else if (done_i && target_i == TARGET_BYTE)
      byte_reg_o <= result_i[7:0];
  end

  // Word pair and fixed product pair kept apart to catch misrouted writes
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pair_reg_o <= ZERO_WORD;
      product_reg_o <= ZERO_WORD;
    end
    else if (done_i && target_i == TARGET_PAIR)
      pair_reg_o <= result_i;
    else if (done_i && target_i == TARGET_PRODUCT)
      product_reg_o <= result_i;
  end

  // Status image is replaced whole on every answer
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      status_reg_o <= '0;
    else if (done_i)
      status_reg_o <= flags_i;
  end
endmodule

// >>> verif/tb_eight_bit_arith_logic_unit.sv
// Self-checking bench of the arithmetic and logic unit with a write-back model
`timescale 1ns/100ps
module tb_eight_bit_arith_logic_unit;
  import alu_pkg::*;

  logic mclk_i = 1'b0;
  logic reset_n_i;
  logic start_i;
  alu_req_t req_i;
  status_t flags_i;
  logic ready_o;
  logic done_o;
  target_t target_o;
  logic [15:0] result_o;
  status_t flags_o;
  logic [7:0] byte_reg;
  logic [15:0] pair_reg;
  logic [15:0] product_reg;
  status_t status_reg;
  int errors = 0;
  int cmp_count = 0;

  // 100 MHz core clock
  always #5 mclk_i = ~mclk_i;

  eight_bit_arith_logic_unit eight_bit_arith_logic_unit_i (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .start_i(start_i), .req_i(req_i), .flags_i(flags_i),
    .ready_o(ready_o), .done_o(done_o), .target_o(target_o), .result_o(result_o),
    .flags_o(flags_o));

  regfile_model regfile_model_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .done_i(done_o), .target_i(target_o), .result_i(result_o), .flags_i(flags_o),
    .byte_reg_o(byte_reg), .pair_reg_o(pair_reg), .product_reg_o(product_reg),
    .status_reg_o(status_reg));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk16(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One request; latency, routing and write-back follow from the operation kind
  task automatic do_op(input alu_op_t op, input logic [7:0] d, input logic [7:0] s,
    input logic [7:0] k, input logic [15:0] p, input status_t fin,
    input logic [15:0] er, input logic [7:0] ef);
    logic w;
    target_t et;
    logic [7:0] n;
    w = op == OP_WORD_SUM_IMMEDIATE || op == OP_WORD_DIFFERENCE_IMMEDIATE;
    et = op >= OP_UNSIGNED_PRODUCT ? TARGET_PRODUCT : w ? TARGET_PAIR : TARGET_BYTE;
    @(posedge mclk_i);
    start_i <= 1'b1;
    req_i <= '{op, d, s, k, p};
    flags_i <= fin;
    @(posedge mclk_i);
    start_i <= 1'b0;
    n = 8'h01;
    #1;
    // Bounded wait so a silent unit cannot hang the run
    while (done_o !== 1'b1 && n < 8'h05)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 8'h05)
    begin
      errors++;
      test_done();
    end
    chk8("latency", n, (w || op >= OP_UNSIGNED_PRODUCT) ? 8'(SLOW_CYCLES) : 8'(FAST_CYCLES));
    chk16("result", result_o, er);
    chk8("flags", flags_o, ef);
    chk8("target", 8'(target_o), 8'(et));
    @(posedge mclk_i);
    #1;
    chk16("model", et == TARGET_BYTE ? {8'h00, byte_reg} :
      et == TARGET_PAIR ? pair_reg : product_reg, er);
    chk8("status", status_reg, ef);
  endtask

  // Reset values, checked during reset and at the first edge after release
  task automatic sc_reset();
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    #1;
    chk8("rst ready", ready_o, 8'h01);
    chk16("rst result", result_o, 16'h0000);
    chk8("rst flags", flags_o, 8'h00);
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk8("rel done", done_o, 8'h00);
    chk8("rel target", 8'(target_o), 8'(TARGET_NONE));
  endtask

  task automatic sc_sum();
    do_op(OP_REG_SUM, 8'h0F, 8'h01, 8'h00, 16'h0000, 8'h00, 16'h0010, 8'h20);
    do_op(OP_REG_SUM_CARRY, 8'hFF, 8'h00, 8'h00, 16'h0000, 8'h01, 16'h0000, 8'h23);
    do_op(OP_WORD_SUM_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'h7FFF, 8'h00, 16'h8000, 8'h0C);
  endtask

  // Borrow chaining: zero survives only when it was already set
  task automatic sc_difference();
    do_op(OP_REG_DIFFERENCE, 8'h10, 8'h01, 8'h00, 16'h0000, 8'h00, 16'h000F, 8'h20);
    do_op(OP_DIFFERENCE_CONSTANT, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h00, 16'h00FF, 8'h25);
    do_op(OP_DIFFERENCE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 16'h0000, 8'h01, 16'h00FF, 8'h25);
    do_op(OP_DIFFERENCE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 16'h0000, 8'h02, 16'h0000, 8'h02);
    do_op(OP_DIFFERENCE_WITH_BORROW, 8'h05, 8'h05, 8'h00, 16'h0000, 8'h00, 16'h0000, 8'h00);
    do_op(OP_DIFFERENCE_BORROW_CONSTANT, 8'h80, 8'h00, 8'h00, 16'h0000, 8'h01, 16'h007F, 8'h28);
    do_op(OP_WORD_DIFFERENCE_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'h0000, 8'h00, 16'hFFFF, 8'h15);
  endtask

  // Carry and half-carry set on entry must come back untouched
  task automatic sc_logic();
    do_op(OP_CONJUNCTION, 8'hF0, 8'h8F, 8'h00, 16'h0000, 8'h21, 16'h0080, 8'h25);
    do_op(OP_CONJUNCTION_CONSTANT, 8'h0F, 8'h00, 8'hF0, 16'h0000, 8'h08, 16'h0000, 8'h02);
    do_op(OP_DISJUNCTION, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h21, 16'h0000, 8'h23);
    do_op(OP_DISJUNCTION_CONSTANT, 8'h01, 8'h00, 8'h80, 16'h0000, 8'h00, 16'h0081, 8'h04);
    do_op(OP_MASK_SET_BITS, 8'h00, 8'h00, 8'h80, 16'h0000, 8'h00, 16'h0080, 8'h04);
    do_op(OP_MASK_CLEAR_BITS, 8'hFF, 8'h00, 8'h0F, 16'h0000, 8'h00, 16'h00F0, 8'h04);
    do_op(OP_ZERO_SIGN_CHECK, 8'h00, 8'h00, 8'h00, 16'h0000, 8'h09, 16'h0000, 8'h03);
  endtask

  task automatic sc_unary();
    do_op(OP_EXCLUSIVE_DISJUNCTION, 8'hFF, 8'h0F, 8'h00, 16'h0000, 8'h00, 16'h00F0, 8'h04);
    do_op(OP_BIT_INVERSION, 8'hFF, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h0000, 8'h03);
    do_op(OP_ARITHMETIC_INVERSE, 8'h80, 8'h00, 8'h00, 16'h0000, 8'h00, 16'h0080, 8'h0D);
    do_op(OP_PLUS_ONE, 8'h7F, 8'h00, 8'h00, 16'h0000, 8'h01, 16'h0080, 8'h0D);
    do_op(OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 16'h0000, 8'h20, 16'h007F, 8'h28);
    do_op(OP_ZERO_REGISTER, 8'h55, 8'h00, 8'h00, 16'h0000, 8'h04, 16'h0000, 8'h02);
    do_op(OP_ALL_ONES_REGISTER, 8'h00, 8'h00, 8'h00, 16'h0000, 8'hFF, 16'h00FF, 8'hFF);
  endtask

  task automatic sc_product();
    do_op(OP_UNSIGNED_PRODUCT, 8'hFF, 8'hFF, 8'h00, 16'h0000, 8'h00, 16'hFE01, 8'h01);
    do_op(OP_SIGNED_PRODUCT, 8'hFF, 8'hFF, 8'h00, 16'h0000, 8'h00, 16'h0001, 8'h00);
    do_op(OP_MIXED_SIGN_PRODUCT, 8'hFF, 8'h02, 8'h00, 16'h0000, 8'h00, 16'hFFFE, 8'h01);
    do_op(OP_FRACTIONAL_UNSIGNED_PRODUCT, 8'h80, 8'h80, 8'h00, 16'h0000, 8'h00, 16'h8000,
      8'h00);
    do_op(OP_FRACTIONAL_SIGNED_PRODUCT, 8'h00, 8'h7F, 8'h00, 16'h0000, 8'h00, 16'h0000,
      8'h02);
    do_op(OP_FRACTIONAL_MIXED_PRODUCT, 8'hFF, 8'h80, 8'h00, 16'h0000, 8'h00, 16'hFF00,
      8'h01);
  endtask

  // Fast sum then product back to back, a request refused while busy, one overlapping done
  task automatic sc_pipeline();
    @(posedge mclk_i);
    start_i <= 1'b1;
    req_i <= '{OP_REG_SUM, 8'h03, 8'h04, 8'h00, 16'h0000};
    flags_i <= '0;
    @(posedge mclk_i);
    req_i <= '{OP_UNSIGNED_PRODUCT, 8'h10, 8'h10, 8'h00, 16'h0000};
    #1 chk16("first sum", result_o, 16'h0007);
    @(posedge mclk_i);
    req_i <= '{OP_BIT_INVERSION, 8'h00, 8'h00, 8'h00, 16'h0000};
    #1 chk8("busy ready", ready_o, 8'h00);
    chk8("busy done", done_o, 8'h00);
    @(posedge mclk_i);
    req_i <= '{OP_ZERO_REGISTER, 8'h55, 8'h00, 8'h00, 16'h0000};
    #1 chk16("product", result_o, 16'h0100);
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1 chk16("after refuse", result_o, 16'h0000);
    chk8("after target", 8'(target_o), 8'(TARGET_BYTE));
    @(posedge mclk_i);
    #1 chk8("idle done", done_o, 8'h00);
  endtask

  initial
  begin
    reset_n_i = 1'b0;
    start_i = 1'b0;
    req_i = '0;
    flags_i = '0;
    sc_reset();
    sc_sum();
    sc_difference();
    sc_logic();
    sc_unary();
    sc_product();
    sc_pipeline();
    sc_reset();
    sc_sum();
    test_done();
  end
endmodule
